/* File: hdl/ssdb_core.sv */
`timescale 1ns/1ps
// Contract
// - Status at offset three, read-only, writes ignored
// - Receive-full bit 7 set on data move
// - Transmit-empty bit 5 tracks empty transmit register
// - Mode fault bit 4 on select low
// - Status read then control one write clears fault
// - 8-bit: status read then low read clears
// - High byte reads never touch receive-full
// - Only armed low write clears transmit-empty
// - Data writes ignored while transmit not empty
// - Low-only write leaves high byte undefined
// - Queued word offered to shifter immediately
// - Word done, flag clear: copy, set flag
// - Second word held while flag set
// - Service before third start moves held word
// - Service after third start discards held word
// - Mode fault raises interrupt when enabled
module ssdb_core (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  // Classic Wishbone slave
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [7:0]         i_wb_adr,
  input  wire logic [3:0]         i_wb_sel,
  input  wire logic [31:0]        i_wb_dat,
  output logic      [31:0]        o_wb_dat,
  output logic                    o_wb_ack,
  // Neighbouring control logic
  input  wire ssdb_pkg::ssdb_cfg_t i_cfg,
  input  wire logic               i_ctrl1_wr,
  input  wire logic               i_ss_n,
  // Shift register hand-off
  input  wire ssdb_pkg::ssdb_rx_t i_rx,
  input  wire logic               i_xfer_start,
  input  wire logic               i_tx_take,
  output logic                    o_tx_valid,
  output logic      [15:0]        o_tx_word,
  output logic                    o_mode_fault,
  output logic                    o_irq
);

  // Register select shared by the access strobes and the read mux
  function automatic logic reg_is(input logic [2:0] at, input logic [2:0] which);
    reg_is = (at == which);
  endfunction : reg_is

  // Bus decode
  logic        ack_r;
  logic [31:0] rdat_r;
  wire         bus_req;
  wire  [2:0]  idx;
  wire         word_hit;
  wire         lane0;
  wire         rd;
  wire         wr;
  wire         rd_status;
  wire         rd_low;
  wire         wr_high;
  wire         wr_low;
  wire         wr_istat;
  wire         wr_imask;

  // A strobe still high in the ack cycle is not a second request
  assign bus_req   = i_wb_cyc & i_wb_stb & ~ack_r;
  assign idx       = i_wb_adr[4:2];
  assign word_hit  = (i_wb_adr[7:5] == 3'h0) & (i_wb_adr[1:0] == 2'h0);
  assign lane0     = i_wb_sel[0];
  assign rd        = bus_req & ~i_wb_we & word_hit;
  assign wr        = bus_req & i_wb_we & word_hit & lane0;
  assign rd_status = rd & reg_is(idx, ssdb_pkg::IDX_STATUS);
  assign rd_low    = rd & reg_is(idx, ssdb_pkg::IDX_DATA_LOW);
  assign wr_high   = wr & reg_is(idx, ssdb_pkg::IDX_DATA_HIGH);
  assign wr_low    = wr & reg_is(idx, ssdb_pkg::IDX_DATA_LOW);
  assign wr_istat  = wr & reg_is(idx, ssdb_pkg::IDX_IRQ_STAT);
  assign wr_imask  = wr & reg_is(idx, ssdb_pkg::IDX_IRQ_MASK);

  // Flags and data
  logic        rx_full_r;
  logic        rx_full_nxt;
  logic        tx_empty_r;
  logic        tx_empty_nxt;
  logic        tx_valid_r;
  logic        fault_r;
  logic        fault_nxt;
  logic        rx_arm_r;
  logic        rx_arm_nxt;
  logic        tx_arm_r;
  logic        tx_arm_nxt;
  logic        flt_arm_r;
  logic        flt_arm_nxt;
  logic [15:0] rx_data_r;
  logic [15:0] rx_data_nxt;
  logic [15:0] held_r;
  logic [15:0] held_nxt;
  logic        held_vld_r;
  logic        held_vld_nxt;
  logic [15:0] tx_word_r;
  logic [15:0] tx_word_nxt;
  logic        irq_r;
  logic [ssdb_pkg::IRQ_BITS-1:0] istat_r;
  logic [ssdb_pkg::IRQ_BITS-1:0] istat_nxt;
  logic [ssdb_pkg::IRQ_BITS-1:0] imask_r;

  // Slave select is a pin: two flops before any logic reads it
  logic       ss_meta_r;
  logic       ss_sync_r;
  logic       ss_prev_r;
  wire        ss_fall;
  wire        fault_set;
  wire  [7:0] status_val;

  assign ss_fall    = ss_prev_r & ~ss_sync_r;
  assign fault_set  = ss_fall & i_cfg.master & i_cfg.fault_detect_en;
  assign status_val = {rx_full_r, 1'b0, tx_empty_r, fault_r, 4'h0};

  // Low-byte read after a qualifying status read services receive-full
  wire rx_service = rd_low & rx_arm_r;
  // Low-byte write after a qualifying status read queues the word
  wire tx_commit  = wr_low & tx_arm_r & tx_empty_r;

  always_comb begin
    rx_full_nxt  = rx_full_r;
    rx_data_nxt  = rx_data_r;
    held_nxt     = held_r;
    held_vld_nxt = held_vld_r;
    rx_arm_nxt   = rx_arm_r;
    if (rd_status && rx_full_r) begin
      rx_arm_nxt = 1'b1;
    end
    // A new transfer start invalidates a held second word
    if (i_xfer_start) begin
      held_vld_nxt = 1'b0;
    end
    if (rx_service) begin
      rx_arm_nxt = 1'b0;
      if (held_vld_r && !i_xfer_start) begin
        rx_data_nxt = held_r;
        held_vld_nxt = 1'b0;
      end else begin
        rx_full_nxt = 1'b0;
      end
    end
    // A word arriving in the clearing cycle is not lost
    if (i_rx.done) begin
      if (!rx_full_nxt) begin
        rx_data_nxt = i_rx.word;
        rx_full_nxt = 1'b1;
      end else begin
        held_nxt     = i_rx.word;
        held_vld_nxt = 1'b1;
      end
    end
  end

  always_comb begin
    tx_empty_nxt = tx_empty_r;
    tx_word_nxt  = tx_word_r;
    tx_arm_nxt   = tx_arm_r;
    if (rd_status && tx_empty_r) begin
      tx_arm_nxt = 1'b1;
    end
    // High byte loads only while empty and never moves the flag
    if (wr_high && tx_empty_r) begin
      tx_word_nxt[15:8] = i_wb_dat[7:0];
    end
    if (wr_low && tx_empty_r) begin
      tx_word_nxt[7:0] = i_wb_dat[7:0];
    end
    // In 8-bit width only the low byte is shifted; a stale high byte is not passed on
    if (tx_commit && !i_cfg.width_16) begin
      tx_word_nxt[15:8] = 8'h00;
    end
    if (tx_commit) begin
      tx_empty_nxt = 1'b0;
      tx_arm_nxt   = 1'b0;
    end
    // Take only comes while a word is queued, so it never meets a commit
    if (i_tx_take) begin
      tx_empty_nxt = 1'b1;
    end
  end

  always_comb begin
    fault_nxt   = fault_r;
    flt_arm_nxt = flt_arm_r;
    if (rd_status && fault_r) begin
      flt_arm_nxt = 1'b1;
    end
    if (i_ctrl1_wr && flt_arm_r) begin
      fault_nxt   = 1'b0;
      flt_arm_nxt = 1'b0;
    end
    if (fault_set)
      fault_nxt = 1'b1;
  end

  // Sticky interrupt events; set wins over write-one-to-clear
  wire [ssdb_pkg::IRQ_BITS-1:0] irq_evt = {fault_nxt & ~fault_r,
                                           tx_empty_nxt & ~tx_empty_r,
                                           rx_full_nxt & ~rx_full_r};
  wire [ssdb_pkg::IRQ_BITS-1:0] irq_clr = wr_istat ? i_wb_dat[ssdb_pkg::IRQ_BITS-1:0]
                                                   : ssdb_pkg::IRQ_RESET;
  assign istat_nxt = (istat_r & ~irq_clr) | irq_evt;

  // Status writes fall through to no register at all
  wire [31:0] rd_mux =
      reg_is(idx, ssdb_pkg::IDX_STATUS)    ? {24'h0, status_val} :
      reg_is(idx, ssdb_pkg::IDX_DATA_HIGH) ? {24'h0, rx_data_r[15:8]} :
      reg_is(idx, ssdb_pkg::IDX_DATA_LOW)  ? {24'h0, rx_data_r[7:0]} :
      reg_is(idx, ssdb_pkg::IDX_IRQ_STAT)  ? {29'h0, istat_r} :
      reg_is(idx, ssdb_pkg::IDX_IRQ_MASK)  ? {29'h0, imask_r} :
                                         ssdb_pkg::UNMAPPED_VAL;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdat_r <= ssdb_pkg::UNMAPPED_VAL;
    end else begin
      rdat_r <= rd ? rd_mux : ssdb_pkg::UNMAPPED_VAL;
    end
  end

  // Reset to the idle high level so no false select edge follows reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ss_meta_r <= 1'b1;
    end else begin
      ss_meta_r <= i_ss_n;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ss_sync_r <= 1'b1;
    end else begin
      ss_sync_r <= ss_meta_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ss_prev_r <= 1'b1;
    end else begin
      ss_prev_r <= ss_sync_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_full_r <= 1'b0;
    end else begin
      rx_full_r <= rx_full_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_arm_r <= 1'b0;
    end else begin
      rx_arm_r <= rx_arm_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_data_r <= ssdb_pkg::DATA_RESET;
    end else begin
      rx_data_r <= rx_data_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      held_r <= ssdb_pkg::DATA_RESET;
    end else begin
      held_r <= held_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      held_vld_r <= 1'b0;
    end else begin
      held_vld_r <= held_vld_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_empty_r <= 1'b1;
    end else begin
      tx_empty_r <= tx_empty_nxt;
    end
  end

  // Own flop so the shifter sees a registered valid, not an inverter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= ~tx_empty_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_arm_r <= 1'b0;
    end else begin
      tx_arm_r <= tx_arm_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_word_r <= ssdb_pkg::DATA_RESET;
    end else begin
      tx_word_r <= tx_word_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flt_arm_r <= 1'b0;
    end else begin
      flt_arm_r <= flt_arm_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      istat_r <= ssdb_pkg::IRQ_RESET;
    end else begin
      istat_r <= istat_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      imask_r <= ssdb_pkg::IRQ_RESET;
    end else if (wr_imask) begin
      imask_r <= i_wb_dat[ssdb_pkg::IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_nxt & imask_r);
    end
  end

  assign o_wb_ack     = ack_r;
  assign o_wb_dat     = rdat_r;
  assign o_tx_valid   = tx_valid_r;
  assign o_tx_word    = tx_word_r;
  assign o_mode_fault = fault_r;
  assign o_irq        = irq_r;

endmodule : ssdb_core

/* File: hdl/ssdb_pkg.sv */
package ssdb_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [2:0] IDX_STATUS    = 3'h3;
  localparam logic [2:0] IDX_DATA_HIGH = 3'h4;
  localparam logic [2:0] IDX_DATA_LOW  = 3'h5;
  localparam logic [2:0] IDX_IRQ_STAT  = 3'h6;
  localparam logic [2:0] IDX_IRQ_MASK  = 3'h7;

  // Status register bit positions
  localparam int BIT_RX_FULL   = 7;
  localparam int BIT_TX_EMPTY  = 5;
  localparam int BIT_MODE_FLT  = 4;

  // Interrupt status and mask bit positions
  localparam int IRQ_RX_FULL   = 0;
  localparam int IRQ_TX_EMPTY  = 1;
  localparam int IRQ_MODE_FLT  = 2;
  localparam int IRQ_BITS      = 3;

  localparam logic [15:0]         DATA_RESET   = 16'h0000;
  localparam logic [IRQ_BITS-1:0] IRQ_RESET    = 3'h0;
  localparam logic [31:0]         UNMAPPED_VAL = 32'h0000_0000;

  // Configuration from the neighbouring control registers
  typedef struct packed {
    logic master;           // unit is master
    logic fault_detect_en;  // fault_detect_enable
    logic width_16;         // transfer_width_select, 1 = 16-bit
  } ssdb_cfg_t;

  // Receive shift register hand-off
  typedef struct packed {
    logic        done;      // one-cycle pulse: a word finished receiving
    logic [15:0] word;
  } ssdb_rx_t;

endpackage : ssdb_pkg

/* File: bench/ssdb_core_sva.sv */
`timescale 1ns/1ps
module ssdb_core_sva (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic        i_tx_take,
  input wire logic        i_ctrl1_wr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_tx_valid,
  input wire logic [15:0] o_tx_word,
  input wire logic        o_mode_fault
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic req;
  logic st_r;
  logic tv_r;
  logic mf_r;
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // Flags as they stood at the taking edge, which is what a status read returns
  always_ff @(posedge i_clk) begin
    st_r <= req && !i_wb_we && i_wb_adr == 8'h0c;
    tv_r <= o_tx_valid;
    mf_r <= o_mode_fault;
  end
  a_ack_next: assert property (req |=> o_wb_ack) else $error("no ack");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  a_status_spare: assert property (o_wb_ack && st_r |-> o_wb_dat[31:8] == 0 && o_wb_dat[6] == 0
    && o_wb_dat[3:0] == 0) else $error("spare bits set");
  a_status_txe: assert property (o_wb_ack && st_r |-> o_wb_dat[5] == !tv_r) else $error("bad txe");
  a_status_fault: assert property (o_wb_ack && st_r |-> o_wb_dat[4] == mf_r) else $error("bad fault");
  a_write_ignored: assert property (req && i_wb_we && o_tx_valid && i_wb_adr[7:3] == 5'h02
    |=> $stable(o_tx_word)) else $error("queued word changed");
  a_take_empties: assert property (i_tx_take |=> !o_tx_valid) else $error("still valid");
  a_fault_holds: assert property (o_mode_fault && !i_ctrl1_wr |=> o_mode_fault) else $error("fault lost");
  c_rx_full: cover property (o_wb_ack && st_r && o_wb_dat[7]);
  c_take: cover property (i_tx_take);
  c_fault: cover property ($rose(o_mode_fault));
endmodule : ssdb_core_sva
bind ssdb_core ssdb_core_sva u_sva (.i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_tx_take,
  .i_ctrl1_wr, .o_wb_dat, .o_wb_ack, .o_tx_valid, .o_tx_word, .o_mode_fault);

/* File: bench/ssdb_peer.sv */
`timescale 1ns/1ps
module ssdb_peer (
  input  wire logic          i_clk,
  input  wire logic          i_hold,
  input  wire logic          i_tx_valid,
  input  wire logic [15:0]   i_tx_word,
  output ssdb_pkg::ssdb_rx_t o_rx,
  output logic               o_take
);
  logic [4:0]  cnt_r = '0;
  logic [15:0] sh_r;
  logic        go;
  initial o_rx = '0;
  initial o_take = 1'b0;
  assign go = i_tx_valid && !i_hold && cnt_r == 0;
  // Echo is the complement, so it is known yet never equal to what was sent
  always @(posedge i_clk) begin
    o_take <= go;
    o_rx.done <= cnt_r == 5'd1;
    o_rx.word <= cnt_r == 5'd1 ? sh_r : ~o_rx.word;
    if (go) begin
      cnt_r <= 5'd12;
      sh_r <= ~i_tx_word;
    end else if (cnt_r != 0) begin
      cnt_r <= cnt_r - 5'd1;
    end
  end
endmodule : ssdb_peer

/* File: bench/ssdb_core_tb.sv */
`timescale 1ns/1ps
module ssdb_core_tb;
  logic                i_clk = 0;
  logic                rst_n = 0, cyc = 0, stb = 0, we = 0, ctl1 = 0, ss_n = 1, hold = 0;
  logic [7:0]          adr = 0;
  logic [31:0]         wdat = 0, rd, o_dat;
  logic                ack, tv, mf, irq, take;
  logic [15:0]         tw, a, b, c;
  ssdb_pkg::ssdb_cfg_t cfg = 3'b101;
  ssdb_pkg::ssdb_rx_t  rx;
  int                  num_errors = 0, total_checks = 0;
  always #5 i_clk = ~i_clk;
  ssdb_core u_dut (.i_clk, .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(o_dat), .o_wb_ack(ack), .i_cfg(cfg), .i_ctrl1_wr(ctl1),
    .i_ss_n(ss_n), .i_rx(rx), .i_xfer_start(take), .i_tx_take(take), .o_tx_valid(tv), .o_tx_word(tw),
    .o_mode_fault(mf), .o_irq(irq));
  ssdb_peer u_peer (.i_clk, .i_hold(hold), .i_tx_valid(tv), .i_tx_word(tw), .o_rx(rx), .o_take(take));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    wdat <= {24'h0, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) num_errors++;
    rd = o_dat;
    cyc <= 0;
    stb <= 0;
    @(posedge i_clk);
  endtask : wb
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    wb(1'b0, ad, 8'h00);
    chk("read", rd, e);
  endtask : rdc
  task automatic send(input logic [15:0] d);
    wb(1'b0, 8'h0c, 8'h00);
    wb(1'b1, 8'h10, d[15:8]);
    wb(1'b1, 8'h14, d[7:0]);
  endtask : send
  task automatic wdone;
    int n;
    n = 0;
    while (rx.done !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    if (rx.done !== 1'b1) num_errors++;
    @(posedge i_clk);
  endtask : wdone
  task automatic pulse;
    ctl1 <= 1;
    @(posedge i_clk);
    ctl1 <= 0;
    repeat (2) @(posedge i_clk);
  endtask : pulse
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    #200000;
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(32'hb6d5));
    repeat (12) @(posedge i_clk);
    rst_n <= 1;
    @(posedge i_clk);
    rdc(8'h0c, 32'h20);
    rdc(8'h10, 32'h0);
    wb(1'b1, 8'h0c, 8'hff);
    rdc(8'h0c, 32'h20);
    rdc(8'h0d, 32'h0);
    for (int i = 0; i < 6; i++) begin
      a = 16'($urandom);
      cfg.width_16 <= i[0];
      send(a);
      wdone();
      rdc(8'h0c, 32'ha0);
      if (i[0]) rdc(8'h10, {24'h0, ~a[15:8]});
      rdc(8'h0c, 32'ha0);
      rdc(8'h14, {24'h0, ~a[7:0]});
      rdc(8'h0c, 32'h20);
    end
    // Stalled shifter keeps the word queued long enough to try overwriting it
    hold <= 1;
    b = 16'($urandom);
    c = 16'($urandom);
    send(b);
    wb(1'b1, 8'h14, ~b[7:0]);
    chk("txword", {16'h0, tw}, {16'h0, b});
    hold <= 0;
    wdone();
    send(c);
    wdone();
    rdc(8'h10, {24'h0, ~b[15:8]});
    rdc(8'h14, {24'h0, ~b[7:0]});
    rdc(8'h0c, 32'ha0);
    rdc(8'h10, {24'h0, ~c[15:8]});
    rdc(8'h14, {24'h0, ~c[7:0]});
    send(a);
    wdone();
    send(b);
    wdone();
    send(c);
    wdone();
    rdc(8'h14, {24'h0, ~a[7:0]});
    rdc(8'h10, {24'h0, ~c[15:8]});
    wb(1'b1, 8'h1c, 8'h04);
    ss_n <= 0;
    repeat (8) @(posedge i_clk);
    chk("fault off", mf, 0);
    ss_n <= 1;
    cfg.fault_detect_en <= 1;
    repeat (4) @(posedge i_clk);
    ss_n <= 0;
    repeat (8) @(posedge i_clk);
    chk("fault irq", {mf, irq}, 2'b11);
    pulse();
    chk("fault kept", mf, 1);
    rdc(8'h0c, 32'hb0);
    pulse();
    chk("fault clr", mf, 0);
    wb(1'b1, 8'h1c, 8'h00);
    chk("masked", irq, 0);
    wb(1'b1, 8'h18, 8'h07);
    wb(1'b1, 8'h1c, 8'h04);
    chk("irq clr", irq, 0);
    results();
  end
endmodule : ssdb_core_tb
